// [pcie_dcs_params.svh]
`ifndef PCIE_DCS_PARAMS_SVH
`define PCIE_DCS_PARAMS_SVH
// Behaviour
// - Control bits 0-3 are read-write error reporting enables, reset to zero.
// - Bit 4 relaxed ordering reads zero; no originated request carries that attribute.
// - Payload field bits 7:5; code 1 is 256 bytes, all others 128.
// - Bit 8 picks tag range 0-31 or 0-255 in sequential-tag debug.
// - Bit 9 phantom function enable always reads zero.
// - Bit 11 no snoop reads zero; never originated, forwarded attribute left untouched.
// - Bits 14:12 read request size read zero and change nothing.
// - Status bits 0-3 latch errors regardless of enables, write-one clears, reset zero.
// - Status bit 4 shows that auxiliary power is detected.
// - Status bit 5 transactions pending always reads zero.
// - Capability register advertises supported payload code 1, meaning 256 bytes.

// ----------------------------------------
// Register indexes (byte address = 4 x index)
// ----------------------------------------
`define IDX_DEV_CAP    10'h044
`define IDX_DEV_CTL    10'h048
`define IDX_DEV_STS    10'h04A
`define IDX_IRQ_STAT   10'h060
`define IDX_IRQ_MASK   10'h061
`define IDX_TL_CTL     10'h062

// ----------------------------------------
// Field positions
// ----------------------------------------
`define POS_REPORT_EN  0
`define POS_PAYLOAD    5
`define POS_EXT_TAG    8
`define POS_AUX_PM     10
`define POS_SEQ_TAG    0

// ----------------------------------------
// Reset and fixed values
// ----------------------------------------
`define RST_REPORT_EN  4'h0
`define RST_PAYLOAD    3'h0
`define RST_IRQ_MASK   4'h0
`define RST_TAG        8'h00
`define SUPPORTED_PAYLOAD_CODE 3'h1
`define PAYLOAD_CODE_256 3'h1
`define PAYLOAD_BYTES_128 9'h080
`define PAYLOAD_BYTES_256 9'h100
`define TAG_MASK_SHORT 8'h1F
`define TAG_MASK_LONG  8'hFF

`endif

// [pcie_dcs_pkg.sv]
package pcie_dcs_pkg;

   // ----------------------------------------
   // Error events, one bit per class
   // ----------------------------------------
   typedef struct packed {
      logic unsupported_request;
      logic fatal;
      logic nonfatal;
      logic correctable;
   } err_s;

   // ----------------------------------------
   // Device control layout
   // ----------------------------------------
   typedef struct packed {
      logic       reserved;
      logic [2:0] read_request_size;
      logic       no_snoop_enable;
      logic       aux_power_pm_enable;
      logic       phantom_function_enable;
      logic       extended_tag_enable;
      logic [2:0] payload_size_select;
      logic       relaxed_order_enable;
      logic [3:0] report_enable;
   } dev_control_s;

   // ----------------------------------------
   // Device status layout
   // ----------------------------------------
   typedef struct packed {
      logic [9:0] reserved;
      logic       transactions_pending;
      logic       aux_power_present;
      logic [3:0] error_flag;
   } dev_status_s;

   // APB access phase
   typedef enum logic [1:0] {
      APB_IDLE = 2'b00,
      APB_DONE = 2'b01
   } apb_phase_e;

endpackage : pcie_dcs_pkg

// [pcie_device_control_status.sv]
`include "pcie_dcs_params.svh"

module pcie_device_control_status
   import pcie_dcs_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        aux_reset,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire err_s        error_event,
   input  wire logic        aux_power_present,
   input  wire logic        tag_request,
   output err_s             report_event,
   output logic [8:0]       payload_bytes,
   output logic [7:0]       seq_tag,
   output logic             relaxed_order_attr,
   output logic             no_snoop_attr,
   output logic             irq
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------

   // Word-aligned match against a register index
   function automatic logic addr_hit(input logic [11:0] a, input logic [9:0] idx);
      addr_hit = (a[11:2] == idx) && (a[1:0] == 2'h0);
   endfunction : addr_hit

   // Keeps a tag inside the selected range
   function automatic logic [7:0] tag_wrap(input logic [7:0] t, input logic ext);
      tag_wrap = t & (ext ? `TAG_MASK_LONG : `TAG_MASK_SHORT);
   endfunction : tag_wrap

   // Reserved payload codes fall back to the smallest size
   function automatic logic [8:0] payload_of(input logic [2:0] code);
      payload_of = (code == `PAYLOAD_CODE_256) ? `PAYLOAD_BYTES_256 : `PAYLOAD_BYTES_128;
   endfunction : payload_of

   // ----------------------------------------
   // State
   // ----------------------------------------
   apb_phase_e  phase_q, phase_d;
   logic [31:0] prdata_q, prdata_d;
   logic        pready_q, pready_d;
   logic        pslverr_q, pslverr_d;
   logic [3:0]  report_en_q, report_en_d;
   logic [2:0]  payload_sel_q, payload_sel_d;
   logic        ext_tag_q, ext_tag_d;
   logic        seq_tag_en_q, seq_tag_en_d;
   logic [3:0]  irq_mask_q, irq_mask_d;
   logic [3:0]  err_flag_q, err_flag_d;
   logic [3:0]  irq_stat_q, irq_stat_d;
   logic        aux_seen_q, aux_seen_d;
   logic        irq_q, irq_d;
   logic        aux_pm_q, aux_pm_d;
   logic        rst_seen_q;
   logic [7:0]  tag_q, tag_d;
   err_s        report_q, report_d;
   logic [8:0]  payload_q, payload_d;

   logic         hit_cap, hit_ctl, hit_sts;
   logic         hit_istat, hit_imask, hit_tl;
   logic         hit_any, commit, wr_commit, rd_commit;
   logic [3:0]   events;
   logic [31:0]  read_word;
   dev_control_s ctl_view;
   dev_status_s  sts_view;

   // ----------------------------------------
   // Address decode and read view
   // ----------------------------------------

   // Decode is purely from paddr, which the master holds steady
   always_comb begin
      hit_cap   = addr_hit(paddr, `IDX_DEV_CAP);
      hit_ctl   = addr_hit(paddr, `IDX_DEV_CTL);
      hit_sts   = addr_hit(paddr, `IDX_DEV_STS);
      hit_istat = addr_hit(paddr, `IDX_IRQ_STAT);
      hit_imask = addr_hit(paddr, `IDX_IRQ_MASK);
      hit_tl    = addr_hit(paddr, `IDX_TL_CTL);
      hit_any   = hit_cap | hit_ctl | hit_sts | hit_istat | hit_imask | hit_tl;
      events    = error_event;
   end

   // Hardwired fields are built as constants so writes can never reach them
   always_comb begin
      ctl_view                         = '0;
      ctl_view.report_enable           = report_en_q;
      ctl_view.relaxed_order_enable    = 1'b0;
      ctl_view.payload_size_select     = payload_sel_q;
      ctl_view.extended_tag_enable     = ext_tag_q;
      ctl_view.phantom_function_enable = 1'b0;
      ctl_view.aux_power_pm_enable     = aux_pm_q;
      ctl_view.no_snoop_enable         = 1'b0;
      ctl_view.read_request_size       = 3'h0;
      sts_view                         = '0;
      sts_view.error_flag              = err_flag_q;
      sts_view.aux_power_present       = aux_seen_q;
      sts_view.transactions_pending    = 1'b0;
   end

   // Read mux; narrow registers sit in the low bits
   always_comb begin
      read_word = 32'h0000_0000;
      if (hit_cap) begin
         read_word[2:0] = `SUPPORTED_PAYLOAD_CODE;
      end
      if (hit_ctl) begin
         read_word[15:0] = ctl_view;
      end
      if (hit_sts) begin
         read_word[15:0] = sts_view;
      end
      if (hit_istat) begin
         read_word[3:0] = irq_stat_q;
      end
      if (hit_imask) begin
         read_word[3:0] = irq_mask_q;
      end
      if (hit_tl) begin
         read_word[`POS_SEQ_TAG] = seq_tag_en_q;
      end
   end

   // ----------------------------------------
   // APB slave
   // ----------------------------------------

   // One wait state keeps pready and prdata straight from flops
   always_comb begin
      phase_d   = phase_q;
      prdata_d  = prdata_q;
      pready_d  = 1'b0;
      pslverr_d = 1'b0;
      commit    = 1'b0;
      unique case (phase_q)
         APB_IDLE: begin
            if (psel && penable) begin
               phase_d   = APB_DONE;
               pready_d  = 1'b1;
               pslverr_d = ~hit_any;
               prdata_d  = pwrite ? 32'h0000_0000 : read_word;
            end
         end
         APB_DONE: begin
            phase_d = APB_IDLE;
            commit  = psel && penable;
         end
         default: begin
            phase_d = APB_IDLE;                             // Unused codes recover to idle
         end
      endcase
      // Misses never commit, so refused accesses change no state
      wr_commit = commit && pwrite && hit_any;
      rd_commit = commit && !pwrite && hit_any;
   end

   // Bus handshake registers
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         phase_q   <= APB_IDLE;
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         phase_q   <= phase_d;
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------

   // Only the writable fields are stored; byte lanes gate each half
   always_comb begin
      report_en_d   = report_en_q;
      payload_sel_d = payload_sel_q;
      ext_tag_d     = ext_tag_q;
      seq_tag_en_d  = seq_tag_en_q;
      irq_mask_d    = irq_mask_q;
      if (wr_commit && hit_ctl && pstrb[0]) begin
         report_en_d   = pwdata[`POS_REPORT_EN +: 4];
         payload_sel_d = pwdata[`POS_PAYLOAD +: 3];
      end
      if (wr_commit && hit_ctl && pstrb[1]) begin
         ext_tag_d = pwdata[`POS_EXT_TAG];
      end
      if (wr_commit && hit_tl && pstrb[0]) begin
         seq_tag_en_d = pwdata[`POS_SEQ_TAG];
      end
      if (wr_commit && hit_imask && pstrb[0]) begin
         irq_mask_d = pwdata[3:0];
      end
   end

   // Fundamental reset clears every enable except the sticky aux power enable
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         report_en_q   <= `RST_REPORT_EN;
         payload_sel_q <= `RST_PAYLOAD;
         ext_tag_q     <= 1'b0;
         seq_tag_en_q  <= 1'b0;
         irq_mask_q    <= `RST_IRQ_MASK;
      end else begin
         report_en_q   <= report_en_d;
         payload_sel_q <= payload_sel_d;
         ext_tag_q     <= ext_tag_d;
         seq_tag_en_q  <= seq_tag_en_d;
         irq_mask_q    <= irq_mask_d;
      end
   end

   // ----------------------------------------
   // Sticky aux power enable
   // ----------------------------------------

   // Marks the first cycle after a fundamental reset
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rst_seen_q <= 1'b1;
      end else begin
         rst_seen_q <= 1'b0;
      end
   end

   // A reset without aux power clears it one cycle late, since an async
   // reset may not look at the aux power pin
   always_comb begin
      aux_pm_d = aux_pm_q;
      if (rst_seen_q && !aux_power_present) begin
         aux_pm_d = 1'b0;
      end
      // A write in the release cycle still wins, as software asked for it
      if (wr_commit && hit_ctl && pstrb[1]) begin
         aux_pm_d = pwdata[`POS_AUX_PM];
      end
   end

   // Only the aux-domain power-on reset touches this flop
   always_ff @(posedge clock or posedge aux_reset) begin
      if (aux_reset) begin
         aux_pm_q <= 1'b0;
      end else begin
         aux_pm_q <= aux_pm_d;
      end
   end

   // ----------------------------------------
   // Status flags and interrupt
   // ----------------------------------------

   // New events win over a clear in the same cycle
   always_comb begin
      err_flag_d = err_flag_q;
      irq_stat_d = irq_stat_q;
      if (wr_commit && hit_sts && pstrb[0]) begin
         err_flag_d = err_flag_q & ~pwdata[3:0];
      end
      // Clear only what the read returned, so an event caught after the
      // read data was latched is not lost
      if (rd_commit && hit_istat) begin
         irq_stat_d = irq_stat_q & ~prdata_q[3:0];
      end
      err_flag_d = err_flag_d | events;
      irq_stat_d = irq_stat_d | events;
      irq_d      = |(irq_stat_d & irq_mask_d);
      aux_seen_d = aux_power_present;
   end

   // Flags log errors whatever the reporting enables say
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         err_flag_q <= 4'h0;
         irq_stat_q <= 4'h0;
         irq_q      <= 1'b0;
         aux_seen_q <= 1'b0;
      end else begin
         err_flag_q <= err_flag_d;
         irq_stat_q <= irq_stat_d;
         irq_q      <= irq_d;
         aux_seen_q <= aux_seen_d;
      end
   end

   // ----------------------------------------
   // Datapath outputs
   // ----------------------------------------

   // Gated reports, payload limit and debug tag counter
   always_comb begin
      report_d  = err_s'(events & report_en_q);
      payload_d = payload_of(payload_sel_q);
      tag_d     = seq_tag_en_q ? tag_wrap(tag_q, ext_tag_q) : `RST_TAG;
      if (seq_tag_en_q && tag_request) begin
         tag_d = tag_wrap(tag_q + 8'h01, ext_tag_q);
      end
   end

   // Output flops
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         report_q  <= '0;
         payload_q <= `PAYLOAD_BYTES_128;
         tag_q     <= `RST_TAG;
      end else begin
         report_q  <= report_d;
         payload_q <= payload_d;
         tag_q     <= tag_d;
      end
   end

   // Attribute outputs are fixed low: never relaxed order, never no snoop
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         relaxed_order_attr <= 1'b0;
         no_snoop_attr      <= 1'b0;
      end else begin
         relaxed_order_attr <= 1'b0;
         no_snoop_attr      <= 1'b0;
      end
   end

   // Every output is a plain copy of its flop, so no logic follows the register
   assign prdata        = prdata_q;
   assign pready        = pready_q;
   assign pslverr       = pslverr_q;
   assign report_event  = report_q;
   assign payload_bytes = payload_q;
   assign seq_tag       = tag_q;
   assign irq           = irq_q;

endmodule : pcie_device_control_status

// [dcs_asserts.sv]
module dcs_asserts
   import pcie_dcs_pkg::*;
(
   input wire logic        clock,
   input wire logic        reset,
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire err_s        error_event,
   input wire logic        aux_power_present,
   input wire err_s        report_event,
   input wire logic [8:0]  payload_bytes,
   input wire logic [7:0]  seq_tag,
   input wire logic        relaxed_order_attr,
   input wire logic        no_snoop_attr
);
   // ----------------------------------------
   // Helper decode
   // ----------------------------------------
   logic       done;
   logic [3:0] evt_v;
   logic [3:0] rep_v;
   logic [2:0] code_v;
   logic       ext_d;
   logic       ext_q;

   // Completed transfer and flattened event vectors
   assign done   = psel && penable && pready;
   assign evt_v  = error_event;
   assign rep_v  = report_event;
   assign code_v = pwdata[7:5];

   // Shadow of the extended tag bit, so the tag range can be judged
   always_comb begin
      ext_d = ext_q;
      if (done && pwrite && paddr == 12'h120 && pstrb[1]) begin
         ext_d = pwdata[8];
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ext_q <= 1'b0;
      end else begin
         ext_q <= ext_d;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_ro_attr;
      !relaxed_order_attr && !no_snoop_attr;
   endproperty
   a_ro_attr: assert property (p_ro_attr)
      else $error("originated attribute set");

   property p_payload;
      done && pwrite && paddr == 12'h120 && pstrb[0]
      |-> ##2 payload_bytes == (($past(code_v, 2) == 3'h1) ? 9'h100 : 9'h080);
   endproperty
   a_payload: assert property (p_payload)
      else $error("payload size wrong");

   property p_report;
      rep_v != 4'h0 |-> (rep_v & ~$past(evt_v)) == 4'h0;
   endproperty
   a_report: assert property (p_report)
      else $error("report without event");

   property p_ctl_ro;
      done && !pwrite && paddr == 12'h120 |-> (prdata & 32'hFFFF_FA10) == 32'h0;
   endproperty
   a_ctl_ro: assert property (p_ctl_ro)
      else $error("control fixed bits not zero");

   property p_sts_ro;
      done && !pwrite && paddr == 12'h128 |-> prdata[31:5] == 27'h0;
   endproperty
   a_sts_ro: assert property (p_sts_ro)
      else $error("status fixed bits not zero");

   property p_sts_aux;
      done && !pwrite && paddr == 12'h128 && $stable(aux_power_present)
      && $past(aux_power_present, 2) == aux_power_present && $past(aux_power_present, 3) == aux_power_present
      |-> prdata[4] == aux_power_present;
   endproperty
   a_sts_aux: assert property (p_sts_aux)
      else $error("aux power bit wrong");

   property p_cap;
      done && !pwrite && paddr == 12'h110 |-> prdata[2:0] == 3'h1;
   endproperty
   a_cap: assert property (p_cap)
      else $error("supported payload code wrong");

   property p_tag_range;
      !ext_q && !$past(ext_q) && !$past(ext_q, 2) |-> seq_tag <= 8'h1F;
   endproperty
   a_tag_range: assert property (p_tag_range)
      else $error("short tag out of range");

endmodule : dcs_asserts

// [testbench.sv]
module testbench
   import pcie_dcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic clock = 0, reset = 1, aux_reset = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, irq, relaxed_order_attr, no_snoop_attr, tag_request = 0, aux_power_present = 0;
   err_s error_event = '0, report_event;
   logic [8:0] payload_bytes;
   logic [7:0] seq_tag;
   logic [32:0] exp_q[$];
   int error_cnt = 0, samples_checked = 0, cyc = 0;

   pcie_device_control_status dut_u (.clock(clock), .reset(reset), .aux_reset(aux_reset), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .error_event(error_event), .aux_power_present(aux_power_present),
      .tag_request(tag_request), .report_event(report_event), .payload_bytes(payload_bytes),
      .seq_tag(seq_tag), .relaxed_order_attr(relaxed_order_attr), .no_snoop_attr(no_snoop_attr), .irq(irq));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   initial begin
      forever #25 clock = ~clock;
   end

   task automatic complete_run();
      chk(33'(exp_q.size()), 33'h0);
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; the answer is judged by the monitor below
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
      exp_q.push_back(e);
      @(posedge clock);
      psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic pulse(input logic [3:0] v);
      error_event <= err_s'(v);
      @(posedge clock);
      error_event <= '0;
      @(posedge clock);
   endtask : pulse

   task automatic req(input int n);
      repeat (n) begin
         tag_request <= 1'b1;
         @(posedge clock);
         tag_request <= 1'b0;
         @(posedge clock);
      end
   endtask : req

   task automatic rst();
      reset <= 1'b1;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
   endtask : rst

   // Monitor pairs every completed transfer with the oldest note
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         complete_run();
      end
      if (psel && penable && pready === 1'b1) begin
         if (exp_q.size() == 0) chk(33'h1_FFFF_FFFF, 33'h0);
         else chk({pslverr, prdata}, exp_q.pop_front());
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] w;
      void'($urandom(8092));
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      aux_reset <= 1'b0;
      xfer(12'h120, 0, 0, 33'h0);
      xfer(12'h128, 0, 0, 33'h0);
      xfer(12'h110, 0, 0, 33'h1);
      for (int c = 0; c < 8; c++) begin
         w = ($urandom() & 32'hFFFF_FF1F) | (c << 5);
         xfer(12'h120, 1, w, 33'h0);
         xfer(12'h120, 0, 0, {1'b0, w & 32'h5EF});
         chk(33'(payload_bytes), (c == 1) ? 33'h100 : 33'h080);
      end
      // Enables 0101 and mask 0011: reporting and irq follow different bits
      xfer(12'h120, 1, 32'h5, 33'h0);
      xfer(12'h184, 1, 32'h3, 33'h0);
      for (int i = 3; i >= 0; i--) begin
         pulse(4'(1 << i));
         chk(33'(report_event), 33'((1 << i) & 5));
         chk(33'(irq), (i < 2) ? 33'h1 : 33'h0);
      end
      xfer(12'h128, 0, 0, 33'hF);
      xfer(12'h180, 0, 0, 33'hF);
      repeat (2) @(posedge clock);
      chk(33'(irq), 33'h0);
      xfer(12'h128, 1, 32'h5, 33'h0);
      xfer(12'h128, 0, 0, 33'hA);
      xfer(12'h128, 1, 32'hFFFF, 33'h0);
      xfer(12'h128, 0, 0, 33'h0);
      // Sticky aux enable survives reset only while aux power exists
      aux_power_present <= 1'b1;
      xfer(12'h120, 1, 32'h400, 33'h0);
      xfer(12'h128, 0, 0, 33'h10);
      rst();
      xfer(12'h120, 0, 0, 33'h400);
      aux_power_present <= 1'b0;
      rst();
      xfer(12'h120, 0, 0, 33'h0);
      // The aux-domain reset clears the sticky enable on its own
      xfer(12'h120, 1, 32'h400, 33'h0);
      xfer(12'h120, 0, 0, 33'h400);
      aux_reset <= 1'b1;
      @(posedge clock);
      aux_reset <= 1'b0;
      xfer(12'h120, 0, 0, 33'h0);
      // Debug tags: wrap at 255, then at 31
      xfer(12'h188, 1, 32'h1, 33'h0);
      xfer(12'h120, 1, 32'h100, 33'h0);
      req(259);
      chk(33'(seq_tag), 33'h3);
      xfer(12'h120, 1, 32'h0, 33'h0);
      req(30);
      chk(33'(seq_tag), 33'h1);
      xfer(12'h188, 1, 32'h0, 33'h0);
      repeat (2) @(posedge clock);
      chk(33'(seq_tag), 33'h0);
      // Refused accesses leave the control register alone
      xfer(12'h1FC, 0, 0, {1'b1, 32'h0});
      xfer(12'h121, 1, 32'hF, {1'b1, 32'h0});
      xfer(12'h120, 0, 0, 33'h0);
      repeat (2) @(posedge clock);
      complete_run();
   end

endmodule : testbench

bind pcie_device_control_status dcs_asserts chk_u (.clock(clock), .reset(reset), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .error_event(error_event), .aux_power_present(aux_power_present), .report_event(report_event),
   .payload_bytes(payload_bytes), .seq_tag(seq_tag), .relaxed_order_attr(relaxed_order_attr),
   .no_snoop_attr(no_snoop_attr));
